// File: lpdac_top.sv
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lpdac_top #(
	parameter int DIAG_UNIT_CYC = lpdac_pkg::DIAG_UNIT_CYC
) (
	input  wire logic                                         CORE_CLK,
	input  wire logic                                         RESETN,
	input  wire logic [lpdac_pkg::ADDR_W-1:0]                 WB_ADR_I,
	input  wire logic [lpdac_pkg::DATA_W-1:0]                 WB_DAT_I,
	output logic      [lpdac_pkg::DATA_W-1:0]                 WB_DAT_O,
	input  wire logic [3:0]                                   WB_SEL_I,
	input  wire logic                                         WB_WE_I,
	input  wire logic                                         WB_CYC_I,
	input  wire logic                                         WB_STB_I,
	output logic                                              WB_ACK_O,
	input  wire logic                                         FAIL_SAFE,
	input  wire logic                                         NV_EXP_CURVE_DEFAULT,
	input  wire logic [lpdac_pkg::NCH*lpdac_pkg::COARSE_W-1:0] NV_COARSE_DUTY_DEFAULT,
	input  wire logic [lpdac_pkg::FREQ_W-1:0]                 NV_DIM_FREQ_DEFAULT,
	input  wire logic                                         NV_INTERNAL_ADDR_SEL,
	input  wire logic                                         ADDR_OR_CLOCK_PIN,
	input  wire logic                                         ADDR_OR_GATE_A_PIN_N,
	input  wire logic                                         ADDR_OR_GATE_B_PIN_N,
	output logic      [lpdac_pkg::NCH-1:0]                    OUT_ON,
	output logic                                              ADC_START,
	output logic      [lpdac_pkg::CONV_CH_W-1:0]              ADC_CHANNEL,
	input  wire logic                                         ADC_DONE,
	input  wire logic [lpdac_pkg::ADC_W-1:0]                  ADC_DATA
);
	localparam int NCH = lpdac_pkg::NCH;
	localparam int CW  = lpdac_pkg::COARSE_W;
	localparam int FW  = lpdac_pkg::FINE_W;
	localparam logic [lpdac_pkg::DCNT_W-1:0] DLY_STEP = lpdac_pkg::DCNT_W'(DIAG_UNIT_CYC);

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);

	// ---------------- bus slave ----------------
	logic                          ack_reg;
	logic [lpdac_pkg::DATA_W-1:0]  dat_o_reg;
	logic [lpdac_pkg::DATA_W-1:0]  rd_data;
	logic                          bus_req;
	logic                          bus_wr;
	logic                          bus_rd;
	logic                          exp_reg, shared_reg, extclk_reg, load_pend_reg, fs_prev_reg;
	logic [lpdac_pkg::FREQ_W-1:0]  freq_reg;
	logic [NCH-1:0]                en_reg;
	logic [lpdac_pkg::DLY_W-1:0]   dly_sel_reg;
	logic [lpdac_pkg::CONV_CH_W-1:0] conv_sel_reg;
	logic                          done_reg, req_pend_reg;
	logic [lpdac_pkg::ADC_W-1:0]   result_reg, supply_reg;
	logic [CW-1:0]                 coarse_reg [NCH];
	logic [FW-1:0]                 fine_reg   [NCH];
	logic [CW-1:0]                 act_coarse [NCH];
	logic [FW-1:0]                 act_fine   [NCH];
	logic [NCH-1:0]                coarse_wr, fine_wr, out_vec;
	lpdac_pkg::lpdac_conv_st_t     conv_st_reg;

	assign bus_req  = WB_CYC_I & WB_STB_I & ~ack_reg;
	// writes land at the edge where the master sees ack, not when first seen
	assign bus_wr   = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;
	assign bus_rd   = bus_req & ~WB_WE_I;
	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = dat_o_reg;

	always_comb begin
		rd_data = '0;
		unique case (WB_ADR_I)
			lpdac_pkg::A_CTRL: begin
				rd_data[lpdac_pkg::CTRL_EXP_BIT]    = exp_reg;
				rd_data[lpdac_pkg::CTRL_SHARED_BIT] = shared_reg;
				rd_data[lpdac_pkg::CTRL_EXTCLK_BIT] = extclk_reg;
				rd_data[lpdac_pkg::CTRL_FREQ_LSB +: lpdac_pkg::FREQ_W] = freq_reg;
			end
			lpdac_pkg::A_ENABLE:      rd_data[NCH-1:0] = en_reg;
			lpdac_pkg::A_DELAY:       rd_data[lpdac_pkg::DLY_W-1:0] = dly_sel_reg;
			lpdac_pkg::A_CONV_SEL:    rd_data[lpdac_pkg::CONV_CH_W-1:0] = conv_sel_reg;
			lpdac_pkg::A_CONV_STAT: begin
				rd_data[lpdac_pkg::STAT_DONE_BIT] = done_reg;
				rd_data[lpdac_pkg::STAT_BUSY_BIT] = req_pend_reg |
					(conv_st_reg != lpdac_pkg::CV_IDLE && conv_st_reg != lpdac_pkg::CV_SUPPLY);
			end
			lpdac_pkg::A_CONV_RESULT: rd_data[lpdac_pkg::ADC_W-1:0] = result_reg;
			lpdac_pkg::A_SUPPLY:      rd_data[lpdac_pkg::ADC_W-1:0] = supply_reg;
			default: begin
				for (int k = 0; k < NCH; k++) begin
					if (WB_ADR_I == lpdac_pkg::ADDR_W'(lpdac_pkg::A_COARSE_BASE
							+ lpdac_pkg::REG_STRIDE * k))
						rd_data[CW-1:0] = coarse_reg[k];
					if (WB_ADR_I == lpdac_pkg::ADDR_W'(lpdac_pkg::A_FINE_BASE
							+ lpdac_pkg::REG_STRIDE * k))
						rd_data[FW-1:0] = fine_reg[k];
				end
			end
		endcase
	end

	// one wait-free answer: ack one cycle after the request is seen
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_reg   <= 1'b0;
			dat_o_reg <= '0;
		end else begin
			ack_reg   <= bus_req;
			dat_o_reg <= bus_rd ? rd_data : '0;
		end
	end

	// ---------------- control registers ----------------
	logic nv_load, ctrl_wr, conv_sel_wr, result_rd;
	assign nv_load     = load_pend_reg | (FAIL_SAFE & ~fs_prev_reg);
	assign ctrl_wr     = bus_wr & WB_SEL_I[0] & (WB_ADR_I == lpdac_pkg::A_CTRL);
	assign conv_sel_wr = bus_wr & WB_SEL_I[0] & (WB_ADR_I == lpdac_pkg::A_CONV_SEL);
	assign result_rd   = WB_CYC_I & WB_STB_I & ~WB_WE_I & ack_reg
		& (WB_ADR_I == lpdac_pkg::A_CONV_RESULT);

	// defaults are taken one edge after release, never under the async reset
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			load_pend_reg <= 1'b1;
			fs_prev_reg   <= 1'b0;
			exp_reg       <= 1'b0;
			shared_reg    <= 1'b0;
			extclk_reg    <= 1'b0;
			freq_reg      <= '0;
		end else begin
			load_pend_reg <= 1'b0;
			fs_prev_reg   <= FAIL_SAFE;
			if (nv_load) begin
				exp_reg  <= NV_EXP_CURVE_DEFAULT;
				freq_reg <= NV_DIM_FREQ_DEFAULT;
			end else if (ctrl_wr) begin
				exp_reg    <= WB_DAT_I[lpdac_pkg::CTRL_EXP_BIT];
				shared_reg <= WB_DAT_I[lpdac_pkg::CTRL_SHARED_BIT];
				extclk_reg <= WB_DAT_I[lpdac_pkg::CTRL_EXTCLK_BIT];
				freq_reg   <= WB_DAT_I[lpdac_pkg::CTRL_FREQ_LSB +: lpdac_pkg::FREQ_W];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			en_reg      <= '0;
			dly_sel_reg <= '0;
		end else if (bus_wr) begin
			if (WB_ADR_I == lpdac_pkg::A_ENABLE) begin
				if (WB_SEL_I[0])
					en_reg[7:0] <= WB_DAT_I[7:0];
				if (WB_SEL_I[1])
					en_reg[NCH-1:8] <= WB_DAT_I[NCH-1:8];
			end
			if (WB_ADR_I == lpdac_pkg::A_DELAY && WB_SEL_I[0])
				dly_sel_reg <= WB_DAT_I[lpdac_pkg::DLY_W-1:0];
		end
	end

	// ---------------- base pulse and period counter ----------------
	logic       clk_s1, clk_s2, clk_s3, gate_a_s1, gate_a_s2, gate_b_s1, gate_b_s2;
	logic [lpdac_pkg::DIV_W-1:0] div_cnt_reg;
	logic [CW-1:0]               cnt_reg;
	logic [FW-1:0]               dith_idx_reg;
	logic       ext_clk_on, base_tick, int_tick, period_start;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			{clk_s1, clk_s2, clk_s3}   <= 3'h0;
			{gate_a_s1, gate_a_s2}     <= 2'h0;
			{gate_b_s1, gate_b_s2}     <= 2'h0;
		end else begin
			clk_s1    <= ADDR_OR_CLOCK_PIN;
			clk_s2    <= clk_s1;
			clk_s3    <= clk_s2;
			gate_a_s1 <= ADDR_OR_GATE_A_PIN_N;
			gate_a_s2 <= gate_a_s1;
			gate_b_s1 <= ADDR_OR_GATE_B_PIN_N;
			gate_b_s2 <= gate_b_s1;
		end
	end

	assign ext_clk_on   = extclk_reg & NV_INTERNAL_ADDR_SEL;
	assign int_tick     = (div_cnt_reg == lpdac_pkg::base_div(freq_reg) - 1'b1);
	assign base_tick    = ext_clk_on ? (clk_s2 & ~clk_s3) : int_tick;
	assign period_start = base_tick & (cnt_reg == lpdac_pkg::CNT_MAX);

	// divisor is at most 4 core cycles at the top rate: 200 ns base pulses
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN)
			div_cnt_reg <= '0;
		else if (int_tick || ext_clk_on)
			div_cnt_reg <= '0;
		else
			div_cnt_reg <= div_cnt_reg + 1'b1;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_reg      <= '0;
			dith_idx_reg <= '0;
		end else if (base_tick) begin
			cnt_reg <= cnt_reg + 1'b1;
			if (period_start)
				dith_idx_reg <= dith_idx_reg + 1'b1;
		end
	end

	property p_period_wrap;
		period_start |=> (cnt_reg == '0) && (dith_idx_reg == $past(dith_idx_reg) + 1'b1);
	endproperty
	a_period_wrap: assert property (p_period_wrap) else $error("period did not wrap at 256");

	// ---------------- per-channel duty and output ----------------
	// bit-reversed index spreads the lengthened periods across the group
	logic [FW-1:0] dith_rev;
	always_comb begin
		for (int b = 0; b < FW; b++)
			dith_rev[b] = dith_idx_reg[FW-1-b];
	end

	logic [CW:0] on_len_q [NCH];

	for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
		localparam logic [lpdac_pkg::ADDR_W-1:0] A_C =
			lpdac_pkg::ADDR_W'(lpdac_pkg::A_COARSE_BASE + lpdac_pkg::REG_STRIDE * gi);
		localparam logic [lpdac_pkg::ADDR_W-1:0] A_F =
			lpdac_pkg::ADDR_W'(lpdac_pkg::A_FINE_BASE + lpdac_pkg::REG_STRIDE * gi);
		logic [CW-1:0]                 nv_c, src_c;
		logic [FW-1:0]                 src_f;
		logic [lpdac_pkg::CODE_W-1:0]  code;
		logic                          gate_off, out_q;

		assign coarse_wr[gi] = bus_wr & WB_SEL_I[0] & (WB_ADR_I == A_C);
		assign fine_wr[gi]   = bus_wr & WB_SEL_I[0] & (WB_ADR_I == A_F);
		assign nv_c          = NV_COARSE_DUTY_DEFAULT[gi*CW +: CW];
		assign src_c         = shared_reg ? act_coarse[0] : act_coarse[gi];
		assign src_f         = shared_reg ? act_fine[0] : act_fine[gi];
		assign gate_off      = NV_INTERNAL_ADDR_SEL &
			((gi < lpdac_pkg::GATE_SPLIT) ? gate_a_s2 : gate_b_s2);

		always_comb begin
			if (FAIL_SAFE)
				code = {nv_c, lpdac_pkg::FINE_ALL};
			else if (exp_reg)
				code = lpdac_pkg::exp_code(src_c);
			else
				code = {src_c, src_f};
		end

		always_ff @(posedge CORE_CLK or negedge RESETN) begin
			if (!RESETN) begin
				coarse_reg[gi] <= '0;
				fine_reg[gi]   <= lpdac_pkg::FINE_ALL;
				act_coarse[gi] <= '0;
				act_fine[gi]   <= lpdac_pkg::FINE_ALL;
			end else if (nv_load) begin
				coarse_reg[gi] <= nv_c;
				fine_reg[gi]   <= lpdac_pkg::FINE_ALL;
				act_coarse[gi] <= nv_c;
				act_fine[gi]   <= lpdac_pkg::FINE_ALL;
			end else begin
				if (coarse_wr[gi]) begin
					coarse_reg[gi] <= WB_DAT_I[CW-1:0];
					act_coarse[gi] <= WB_DAT_I[CW-1:0];
					act_fine[gi]   <= fine_reg[gi];
				end
				if (fine_wr[gi])
					fine_reg[gi] <= WB_DAT_I[FW-1:0];
			end
		end

		always_ff @(posedge CORE_CLK or negedge RESETN) begin
			if (!RESETN) begin
				on_len_q[gi] <= '0;
				out_q        <= 1'b0;
			end else begin
				if (period_start)
					on_len_q[gi] <= {1'b0, code[lpdac_pkg::CODE_W-1:FW]} +
						(CW+1)'(dith_rev <= code[FW-1:0]);
				out_q <= en_reg[gi] & ~gate_off & ({1'b0, cnt_reg} < on_len_q[gi]);
			end
		end

		assign OUT_ON[gi]  = out_q;
		assign out_vec[gi] = out_q;
	end

	property p_off_when_disabled;
		1'b1 |=> ((OUT_ON & ~$past(en_reg)) == '0);
	endproperty
	a_off_when_disabled: assert property (p_off_when_disabled) else $error("disabled output on");

	property p_gate_a_blocks;
		(NV_INTERNAL_ADDR_SEL && gate_a_s2) |=> (OUT_ON[lpdac_pkg::GATE_SPLIT-1:0] == '0);
	endproperty
	a_gate_a_blocks: assert property (p_gate_a_blocks) else $error("gate a high, output on");

	property p_active_holds;
		(!coarse_wr[0] && !nv_load) |=> $stable(act_coarse[0]) && $stable(act_fine[0]);
	endproperty
	a_active_holds: assert property (p_active_holds) else $error("active duty moved");

	property p_coarse_takes_fine;
		(coarse_wr[0] && !nv_load) |=> (act_fine[0] == $past(fine_reg[0]))
			&& (act_coarse[0] == $past(WB_DAT_I[CW-1:0]));
	endproperty
	a_coarse_takes_fine: assert property (p_coarse_takes_fine) else $error("coarse write lost");

	property p_steady_full_fine;
		(period_start && !FAIL_SAFE && !exp_reg && !shared_reg && act_fine[1] == lpdac_pkg::FINE_ALL)
			|=> (on_len_q[1] == {1'b0, $past(act_coarse[1])} + 1'b1);
	endproperty
	a_steady_full_fine: assert property (p_steady_full_fine) else $error("fine F not steady");

	property p_nv_reload;
		nv_load |=> (fine_reg[2] == lpdac_pkg::FINE_ALL)
			&& (coarse_reg[2] == $past(NV_COARSE_DUTY_DEFAULT[2*CW +: CW]))
			&& (freq_reg == $past(NV_DIM_FREQ_DEFAULT));
	endproperty
	a_nv_reload: assert property (p_nv_reload) else $error("defaults not reloaded");

	// ---------------- converter control ----------------
	logic [lpdac_pkg::DCNT_W-1:0]  dly_cnt_reg;
	logic                          start_reg, on_prev_reg;
	logic [lpdac_pkg::CONV_CH_W-1:0] adc_ch_reg;
	logic                          sel_is_out, sel_on_now, user_set;
	logic [3:0]                    sel_idx;

	assign sel_is_out = (conv_sel_reg >= lpdac_pkg::CONV_OUT_FIRST)
		&& (conv_sel_reg <= lpdac_pkg::CONV_OUT_LAST);
	assign sel_idx    = 4'(conv_sel_reg - lpdac_pkg::CONV_OUT_FIRST);
	assign sel_on_now = out_vec[sel_idx];
	assign user_set   = (conv_st_reg == lpdac_pkg::CV_USER) & ADC_DONE;
	assign ADC_START   = start_reg;
	assign ADC_CHANNEL = adc_ch_reg;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_sel_reg <= lpdac_pkg::CONV_SUPPLY_CH;
			req_pend_reg <= 1'b0;
		end else if (conv_sel_wr) begin
			conv_sel_reg <= WB_DAT_I[lpdac_pkg::CONV_CH_W-1:0];
			req_pend_reg <= 1'b1;
		end else if (conv_st_reg == lpdac_pkg::CV_IDLE) begin
			req_pend_reg <= 1'b0;
		end
	end

	// a finishing conversion beats a same-cycle clear
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN)
			done_reg <= 1'b0;
		else if (user_set)
			done_reg <= 1'b1;
		else if (conv_sel_wr || result_rd)
			done_reg <= 1'b0;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_st_reg <= lpdac_pkg::CV_IDLE;
			start_reg   <= 1'b0;
			adc_ch_reg  <= lpdac_pkg::CONV_SUPPLY_CH;
			dly_cnt_reg <= '0;
			on_prev_reg <= 1'b0;
			result_reg  <= '0;
			supply_reg  <= '0;
		end else begin
			start_reg   <= 1'b0;
			on_prev_reg <= sel_on_now;
			unique case (conv_st_reg)
				lpdac_pkg::CV_IDLE: begin
					if (req_pend_reg && sel_is_out && en_reg[sel_idx]) begin
						conv_st_reg <= lpdac_pkg::CV_WAIT_ON;
					end else if (req_pend_reg) begin
						start_reg   <= 1'b1;
						adc_ch_reg  <= conv_sel_reg;
						conv_st_reg <= lpdac_pkg::CV_USER;
					end else begin
						start_reg   <= 1'b1;
						adc_ch_reg  <= lpdac_pkg::CONV_SUPPLY_CH;
						conv_st_reg <= lpdac_pkg::CV_SUPPLY;
					end
				end
				lpdac_pkg::CV_SUPPLY: begin
					if (ADC_DONE) begin
						supply_reg  <= ADC_DATA;
						conv_st_reg <= lpdac_pkg::CV_IDLE;
					end
				end
				lpdac_pkg::CV_WAIT_ON: begin
					if (conv_sel_wr) begin
						conv_st_reg <= lpdac_pkg::CV_IDLE;
					end else if (sel_on_now && !on_prev_reg) begin
						dly_cnt_reg <= lpdac_pkg::DCNT_W'(dly_sel_reg) * DLY_STEP;
						conv_st_reg <= lpdac_pkg::CV_WAIT_DLY;
					end
				end
				lpdac_pkg::CV_WAIT_DLY: begin
					if (conv_sel_wr) begin
						conv_st_reg <= lpdac_pkg::CV_IDLE;
					end else if (dly_cnt_reg == '0) begin
						start_reg   <= 1'b1;
						adc_ch_reg  <= conv_sel_reg;
						conv_st_reg <= lpdac_pkg::CV_USER;
					end else begin
						dly_cnt_reg <= dly_cnt_reg - 1'b1;
					end
				end
				lpdac_pkg::CV_USER: begin
					if (ADC_DONE) begin
						result_reg  <= ADC_DATA;
						conv_st_reg <= lpdac_pkg::CV_IDLE;
					end
				end
				default: conv_st_reg <= lpdac_pkg::CV_IDLE;
			endcase
		end
	end

	sequence s_user_finish;
		(conv_st_reg == lpdac_pkg::CV_USER) && ADC_DONE;
	endsequence
	property p_user_done;
		s_user_finish |=> done_reg && (result_reg == $past(ADC_DATA))
			&& (conv_st_reg == lpdac_pkg::CV_IDLE);
	endproperty
	a_user_done: assert property (p_user_done) else $error("done or result not set");

	property p_sel_write_clears;
		(conv_sel_wr && !user_set) |=> !done_reg && req_pend_reg;
	endproperty
	a_sel_write_clears: assert property (p_sel_write_clears) else $error("select did not clear");

	property p_read_clears;
		(result_rd && !user_set) |=> !done_reg;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("result read kept done");

	property p_supply_store;
		// a pending user request takes the next slot instead of the supply
		(conv_st_reg == lpdac_pkg::CV_SUPPLY && ADC_DONE && !req_pend_reg && !conv_sel_wr)
			|=> (supply_reg == $past(ADC_DATA))
			##1 (ADC_START && ADC_CHANNEL == lpdac_pkg::CONV_SUPPLY_CH);
	endproperty
	a_supply_store: assert property (p_supply_store) else $error("supply not stored/restarted");

	sequence s_turn_on;
		(conv_st_reg == lpdac_pkg::CV_WAIT_ON) && sel_on_now && !on_prev_reg && !conv_sel_wr
			&& dly_sel_reg == '0;
	endsequence
	property p_sample_after_on;
		s_turn_on |=> (conv_st_reg == lpdac_pkg::CV_WAIT_DLY) ##1 ADC_START;
	endproperty
	a_sample_after_on: assert property (p_sample_after_on) else $error("turn-on sample late");
endmodule : lpdac_top

// File: lpdac_pkg.sv
package lpdac_pkg;
	localparam int CLK_HZ        = 20_000_000;
	localparam int NCH           = 12;
	localparam int COARSE_W      = 8;
	localparam int FINE_W        = 4;
	localparam int CODE_W        = 12;
	localparam int FREQ_W        = 4;
	localparam int CONV_CH_W     = 5;
	localparam int ADC_W         = 8;
	localparam int DLY_W         = 4;
	localparam int DIV_W         = 9;
	localparam int DCNT_W        = 10;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 32;
	localparam int PWM_STEPS     = 256;
	localparam int GATE_SPLIT    = 6;
	localparam int REG_STRIDE    = 4;
	// time per step of the sample delay field, and its cycle count
	localparam int DIAG_UNIT_NS  = 1000;
	localparam int DIAG_UNIT_CYC = (DIAG_UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	localparam logic [COARSE_W-1:0]  CNT_MAX         = 8'hFF;
	localparam logic [FINE_W-1:0]    FINE_ALL        = 4'hF;
	localparam logic [CONV_CH_W-1:0] CONV_SUPPLY_CH  = 5'h01;
	localparam logic [CONV_CH_W-1:0] CONV_OUT_FIRST  = 5'h10;
	localparam logic [CONV_CH_W-1:0] CONV_OUT_LAST   = 5'h1B;
	localparam logic [12:0]          EXP_OFFSET      = 13'h0010;

	localparam logic [ADDR_W-1:0] A_CTRL        = 8'h00;
	localparam logic [ADDR_W-1:0] A_ENABLE      = 8'h04;
	localparam logic [ADDR_W-1:0] A_DELAY       = 8'h08;
	localparam logic [ADDR_W-1:0] A_CONV_SEL    = 8'h0C;
	localparam logic [ADDR_W-1:0] A_CONV_STAT   = 8'h10;
	localparam logic [ADDR_W-1:0] A_CONV_RESULT = 8'h14;
	localparam logic [ADDR_W-1:0] A_SUPPLY      = 8'h18;
	localparam logic [ADDR_W-1:0] A_COARSE_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] A_FINE_BASE   = 8'h80;

	localparam int CTRL_EXP_BIT    = 0;
	localparam int CTRL_SHARED_BIT = 1;
	localparam int CTRL_EXTCLK_BIT = 2;
	localparam int CTRL_FREQ_LSB   = 4;
	localparam int STAT_DONE_BIT   = 0;
	localparam int STAT_BUSY_BIT   = 1;

	typedef enum logic [2:0] {
		CV_IDLE     = 3'h0,
		CV_SUPPLY   = 3'h1,
		CV_WAIT_ON  = 3'h2,
		CV_WAIT_DLY = 3'h3,
		CV_USER     = 3'h4
	} lpdac_conv_st_t;

	function automatic int dim_freq_hz(input logic [FREQ_W-1:0] s);
		unique case (s)
			4'h0: return 200;
			4'h1: return 250;
			4'h2: return 300;
			4'h3: return 400;
			4'h4: return 500;
			4'h5: return 600;
			4'h6: return 800;
			4'h7: return 1000;
			4'h8: return 1200;
			4'h9: return 1600;
			4'hA: return 2000;
			4'hB: return 2500;
			4'hC: return 3200;
			4'hD: return 5000;
			4'hE: return 10000;
			4'hF: return 20800;
		endcase
	endfunction : dim_freq_hz

	// core cycles per base pulse, rounded to nearest
	function automatic logic [DIV_W-1:0] base_div(input logic [FREQ_W-1:0] s);
		int f;
		f = dim_freq_hz(s);
		return DIV_W'((CLK_HZ + f * PWM_STEPS / 2) / (f * PWM_STEPS));
	endfunction : base_div

	// piecewise exponential: 32 steps per octave, code 0 at input 0
	function automatic logic [CODE_W-1:0] exp_code(input logic [COARSE_W-1:0] c);
		logic [12:0] m;
		m = 13'({1'b1, c[4:0]}) << c[7:5];
		return CODE_W'((m >> 1) - EXP_OFFSET);
	endfunction : exp_code
endpackage : lpdac_pkg

// File: lpdac_conv_model.sv
`timescale 1ns/1ps
module lpdac_conv_model (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [4:0] chan,
	output logic            done,
	output logic [7:0]      data
);
	int cnt = 0;
	initial done = 1'b0;
	initial data = 8'h00;
	// data toggles outside the done pulse so a sample one cycle late does not match
	always @(posedge clk) begin
		done <= (cnt == 1);
		data <= (cnt == 1) ? (8'hA0 ^ {3'h0, chan}) : ~data;
		cnt <= start ? 6 : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule : lpdac_conv_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int PER = 1024; // 256 base pulses of 4 cycles at 20.8 kHz
	logic        clk    = 1'b0;
	logic        rst_n  = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [31:0] dat    = 32'h0000_0000;
	logic        we     = 1'b0;
	logic        stb    = 1'b0;
	logic [3:0]  sel    = 4'hF;
	logic        fs     = 1'b0;
	logic [1:0]  gate_n = 2'h0;
	logic [4:0]  ediv   = 5'h00;
	logic [31:0] rd;
	logic [31:0] dout;
	logic        ack;
	logic [11:0] on;
	logic        start;
	logic        done;
	logic [4:0]  ch;
	logic [7:0]  adata;
	int          num_errors = 0;
	int          n_tests = 0;
	int          i;
	always #25 clk = ~clk;
	// external base clock at 1/32 of the core rate, kept under 1 MHz
	always @(posedge clk) ediv <= ediv + 5'h01;
	lpdac_top #(.DIAG_UNIT_CYC(1)) uut (.CORE_CLK(clk), .RESETN(rst_n), .WB_ADR_I(adr),
		.WB_DAT_I(dat), .WB_DAT_O(dout), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(stb),
		.WB_STB_I(stb), .WB_ACK_O(ack), .FAIL_SAFE(fs), .NV_EXP_CURVE_DEFAULT(1'b0),
		.NV_COARSE_DUTY_DEFAULT({80'h0, 8'h07, 8'h03}), .NV_DIM_FREQ_DEFAULT(4'hF),
		.NV_INTERNAL_ADDR_SEL(1'b1), .ADDR_OR_CLOCK_PIN(ediv[4]),
		.ADDR_OR_GATE_A_PIN_N(gate_n[0]),
		.ADDR_OR_GATE_B_PIN_N(gate_n[1]), .OUT_ON(on), .ADC_START(start), .ADC_CHANNEL(ch),
		.ADC_DONE(done), .ADC_DATA(adata));
	lpdac_conv_model conv (.clk(clk), .start(start), .chan(ch), .done(done), .data(adata));
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		adr <= a;
		dat <= d;
		we <= w;
		stb <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 8);
		rd = dout;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : bus
	// skips one period so a new duty has landed, then counts whole periods
	task automatic cnt(input int c, input int n, input int exp);
		int s;
		s = 0;
		repeat (PER + 8) @(posedge clk);
		repeat (n * PER) begin
			@(posedge clk);
			if (on[c] === 1'b1) s++;
		end
		chk(s, exp);
	endtask : cnt
	// length in core cycles of the next whole on pulse of channel c
	task automatic pulse(input int c, input int exp);
		int s;
		int k;
		s = 0;
		k = 0;
		while (on[c] !== 1'b0 && k < 16 * PER) begin
			@(posedge clk);
			k++;
		end
		while (on[c] !== 1'b1 && k < 16 * PER) begin
			@(posedge clk);
			k++;
		end
		while (on[c] === 1'b1 && k < 16 * PER) begin
			@(posedge clk);
			k++;
			s++;
		end
		chk(s, exp);
	endtask : pulse
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		bus(0, 8'h00, 0); chk(rd, 32'h0000_00F0);
		bus(0, 8'h04, 0); chk(rd, 0);
		bus(0, 8'h80, 0); chk(rd, 32'h0000_000F);
		bus(0, 8'hFC, 0); chk(rd, 0);
		$display("register test ended");
		repeat (20) @(posedge clk);
		bus(0, 8'h18, 0); chk(rd, 32'h0000_00A1);
		bus(1, 8'h0C, 32'h0000_0005); bus(0, 8'h10, 0); chk(rd[0], 0);
		for (i = 0; i < 50 && rd[0] !== 1'b1; i++) bus(0, 8'h10, 0);
		chk(rd[0], 1);
		bus(0, 8'h14, 0); chk(rd, 32'h0000_00A5);
		bus(0, 8'h10, 0); chk(rd[0], 0);
		$display("conversion test ended");
		bus(1, 8'h04, 32'h0000_0043);
		bus(1, 8'h40, 32'h0000_0001); cnt(0, 2, 16);
		bus(1, 8'h80, 0); cnt(0, 2, 16);
		bus(1, 8'h40, 32'h0000_0001); cnt(0, 16, 68);
		bus(1, 8'h00, 32'h0000_00F1); bus(1, 8'h40, 32'h0000_0020); cnt(0, 16, 68);
		fs <= 1'b1; cnt(0, 2, 32);
		fs <= 1'b0; cnt(1, 2, 64);
		bus(1, 8'h00, 32'h0000_00F2); cnt(1, 2, 32);
		gate_n <= 2'h1; cnt(0, 2, 0);
		cnt(6, 2, 32);
		pulse(6, 16);
		bus(1, 8'h0C, 32'h0000_0016);
		for (i = 0; i < 2000 && rd[0] !== 1'b1; i++) bus(0, 8'h10, 0);
		chk(rd[0], 1);
		bus(0, 8'h14, 0); chk(rd, 32'h0000_00B6);
		bus(1, 8'h00, 32'h0000_00F6); pulse(6, 128);
		$display("dimming test ended");
		tally_and_finish();
	end
endmodule : testbench
